// [src/hpc_pkg.sv]
// Purpose: shared constants for the host port pin control block
// Assumes: one 200 MHz clock, clk_sys
// Notes: register index encodings follow the two select pins
`default_nettype none
package hpc_pkg;
    localparam int HPC_DATA_W = 8;
    localparam int HPC_ADDR_W = 2;
    localparam int HPC_FIFO_DEPTH = 8;
    localparam int HPC_FIFO_W = 11; // byte, index, byte_id
    localparam logic HPC_IRQ_IDLE = 1'h1;
    localparam logic HPC_STRAP_RST = 1'h0;
    localparam logic [1:0] HPC_REG_NUM = 2'h3; // three host registers
    typedef enum logic {HPC_DIR_WRITE, HPC_DIR_READ} hpc_dir_t;
endpackage
`default_nettype wire

// [src/hpc_fifo.sv]
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, async active-low reset
// Notes: full and empty are exact; no write when full
`default_nettype none
module hpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys, // clock
    input wire logic rstn, // async reset
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // not empty
    input wire logic out_ready, // read accept
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule
`default_nettype wire

// [src/hpc_host_port.sv]
// Purpose: pin-level control of the byte-wide host port
// Assumes: host pins are asynchronous and pass two flip-flops first
// Notes: written bytes queue in a FIFO toward the core side
// Operation
// - transfers timed from the two data strobes
// - address latched on the address strobe
// - direction level picks read or write
// - ready output tells host next transfer
// - ready and interrupt float when outputs disabled
// - interrupt driven high during reset
// - disabled port lets interrupt carry timer
// - strap sampled at reset release, high enables
// - open or low strap disables port
// - strap ignored after disable until reset
// - pull-ups on only when port disabled
// - two select inputs pick one register
// - byte id marks first or second byte
`default_nettype none
module hpc_host_port
    import hpc_pkg::*;
#(
    parameter int FIFO_DEPTH = HPC_FIFO_DEPTH
) (
    input wire logic clk_sys, // 200 MHz clock
    input wire logic rstn, // async reset, chip_reset_n
    input wire logic port_enable_strap, // strap pin
    input wire logic port_select_n, // host chip select
    input wire logic data_strobe_a_n, // host strobe a
    input wire logic data_strobe_b_n, // host strobe b
    input wire logic addr_strobe_n, // host address strobe
    input wire logic addr_mux_mode, // 1: host muxes address
    input wire logic xfer_direction, // 1 read, 0 write
    input wire logic reg_select_0, // register select bit 0
    input wire logic reg_select_1, // register select bit 1
    input wire logic byte_id, // second byte when high
    input wire logic [7:0] host_data_in, // data pins in
    output logic [7:0] host_data_out, // data pins out
    output logic host_data_oe, // data pins driven
    input wire logic out_disable_n, // global output disable
    input wire logic timer_b_out, // timer output
    input wire logic timer_on_irq, // route timer to irq pin when port disabled
    input wire logic core_irq_req, // core asks host irq
    input wire logic [7:0] core_rd_data, // read data for host
    input wire logic core_rd_valid, // read data ready
    output logic core_rd_req, // read request pulse
    output logic [1:0] core_rd_index, // register to read
    output logic core_wr_valid, // write word valid
    input wire logic core_wr_ready, // core accepts word
    output logic [10:0] core_wr_word, // {byte_id,index,data}
    output logic port_ready, // ready pin out
    output logic port_ready_oe, // ready pin enable
    output logic host_irq_n, // interrupt pin out
    output logic host_irq_oe, // interrupt pin enable
    output logic port_enabled, // port enabled state
    output logic pullup_on // host pin pull-ups on
);
    typedef enum logic [1:0] {HPC_IDLE, HPC_RD_WAIT, HPC_ACTIVE}
        hpc_state_t;
    localparam int NS = 9;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic [1:0] strap_sync;
    logic cs_s;
    logic ds_s;
    logic as_s;
    logic dir_s;
    logic bid_s;
    logic mux_s;
    logic ds_d;
    logic as_d;
    logic [1:0] sel_s;
    logic [7:0] data_s1;
    logic [7:0] data_s;
    logic strap_seen;
    logic strap_done;
    logic [1:0] addr_latch;
    hpc_state_t state;
    logic fifo_in_ready;
    logic [1:0] idx;
    logic strobe;
    logic read_take;
    logic write_take;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync1 <= '1;
            sync2 <= '1;
            data_s1 <= '0;
            data_s <= '0;
        end else begin
            sync1 <= {port_select_n, data_strobe_a_n, data_strobe_b_n,
                      addr_strobe_n, xfer_direction, byte_id,
                      reg_select_1, reg_select_0, addr_mux_mode};
            sync2 <= sync1;
            data_s1 <= host_data_in;
            data_s <= data_s1;
        end
    end
    assign cs_s = !sync2[8];
    assign ds_s = !(sync2[7] && sync2[6]);
    assign as_s = !sync2[5];
    assign dir_s = sync2[4];
    assign bid_s = sync2[3];
    assign sel_s = sync2[2:1];
    assign strobe = cs_s && ds_s && !ds_d && port_enabled;

    // strap synchroniser runs through reset, so the settled pin level
    // is already at its second stage when reset lets go
    always_ff @(posedge clk_sys) begin
        strap_sync <= {strap_sync[0], port_enable_strap};
    end

    // strap taken once, on the first clock after reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strap_done <= 1'b0;
            port_enabled <= HPC_STRAP_RST;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            port_enabled <= strap_sync[1];
        end
    end
    assign strap_seen = strap_done;
    assign pullup_on = strap_seen ? !port_enabled : 1'b1;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ds_d <= 1'b0;
            as_d <= 1'b0;
            addr_latch <= '0;
        end else begin
            ds_d <= ds_s;
            as_d <= as_s;
            if (as_s && !as_d && cs_s) begin
                addr_latch <= sel_s;
            end
        end
    end
    assign mux_s = sync2[0];
    assign idx = mux_s ? addr_latch : sel_s;
    assign read_take = strobe && state == HPC_IDLE &&
                       dir_s == HPC_DIR_READ;
    assign write_take = strobe && state == HPC_IDLE &&
                        dir_s == HPC_DIR_WRITE;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= HPC_IDLE;
        end else begin
            unique case (state)
                HPC_IDLE: begin
                    if (read_take) begin
                        state <= HPC_RD_WAIT;
                    end else if (write_take) begin
                        state <= HPC_ACTIVE;
                    end
                end
                HPC_RD_WAIT: begin
                    if (core_rd_valid) begin
                        state <= HPC_ACTIVE;
                    end
                end
                HPC_ACTIVE: begin
                    if (!ds_s || !cs_s) begin
                        state <= HPC_IDLE;
                    end
                end
            endcase
        end
    end

    // one-cycle request toward the core, index held for the answer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            core_rd_req <= 1'b0;
            core_rd_index <= '0;
        end else begin
            core_rd_req <= read_take;
            if (read_take) begin
                core_rd_index <= idx;
            end
        end
    end

    // data pins carry the core's byte until the host ends the strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            host_data_out <= '0;
            host_data_oe <= 1'b0;
        end else if (state == HPC_RD_WAIT && core_rd_valid) begin
            host_data_out <= core_rd_data;
            host_data_oe <= out_disable_n;
        end else if (state == HPC_ACTIVE && (!ds_s || !cs_s)) begin
            host_data_oe <= 1'b0;
        end
    end

    hpc_fifo #(
        .WIDTH(HPC_FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(write_take),
        .in_ready(fifo_in_ready),
        .in_data({bid_s, idx, data_s}),
        .out_valid(core_wr_valid),
        .out_ready(core_wr_ready),
        .out_data(core_wr_word)
    );

    // ready low while a read waits or writes cannot queue
    assign port_ready = port_enabled && fifo_in_ready &&
                        state != HPC_RD_WAIT;
    assign port_ready_oe = out_disable_n;
    assign host_irq_oe = out_disable_n;
    always_comb begin
        if (!rstn) begin
            host_irq_n = HPC_IRQ_IDLE;
        end else if (!port_enabled && timer_on_irq) begin
            host_irq_n = timer_b_out;
        end else begin
            host_irq_n = !(core_irq_req && port_enabled);
        end
    end
endmodule
`default_nettype wire

// [sim/hpc_host_port_properties.sv]
// Purpose: concurrent checks on the host port pins
// Assumes: one clk_sys domain, rstn async low
// Notes: bound into every hpc_host_port
`default_nettype none
module hpc_host_port_chk (
    input wire logic clk_sys, // clock
    input wire logic rstn, // async reset
    input wire logic port_select_n, // host select
    input wire logic data_strobe_a_n, // write strobe
    input wire logic data_strobe_b_n, // read strobe
    input wire logic xfer_direction, // 1 read
    input wire logic out_disable_n, // output disable
    input wire logic timer_b_out, // timer level
    input wire logic timer_on_irq, // timer routing
    input wire logic core_irq_req, // core irq
    input wire logic core_rd_valid, // read data valid
    input wire logic host_data_oe, // data pins driven
    input wire logic core_rd_req, // read request
    input wire logic [7:0] core_rd_data, // core read byte
    input wire logic [7:0] host_data_out, // data pins out
    input wire logic core_wr_valid, // fifo head valid
    input wire logic port_ready, // ready pin
    input wire logic port_ready_oe, // ready enable
    input wire logic host_irq_n, // irq pin
    input wire logic host_irq_oe, // irq enable
    input wire logic port_enabled, // port on
    input wire logic pullup_on // pull-ups on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_oe;
        port_ready_oe == out_disable_n && host_irq_oe == out_disable_n;
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_pull; pullup_on == !port_enabled; endproperty
    a_pull: assert property (p_pull) else $error("pull-ups wrong");
    property p_tmr;
        !port_enabled && timer_on_irq |-> host_irq_n == timer_b_out;
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer not on irq");
    property p_irq; port_enabled && core_irq_req |-> !host_irq_n; endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
    property p_hold; $past(rstn) |=> $stable(port_enabled); endproperty
    a_hold: assert property (p_hold) else $error("enable moved");
    property p_wr;
        $fell(data_strobe_a_n) && !port_select_n && !xfer_direction
            && port_enabled && port_ready |-> ##[1:4] core_wr_valid;
    endproperty
    a_wr: assert property (p_wr) else $error("write not queued");
    property p_rd;
        $fell(data_strobe_b_n) && !port_select_n && xfer_direction
            && port_enabled && port_ready |-> ##[1:4] core_rd_req;
    endproperty
    a_rd: assert property (p_rd) else $error("read not requested");
    property p_rdat;
        core_rd_valid |=> host_data_oe && host_data_out == $past(core_rd_data);
    endproperty
    a_rdat: assert property (p_rdat) else $error("read data lost");
    property p_drop; $rose(port_select_n) |-> ##[1:6] !host_data_oe; endproperty
    a_drop: assert property (p_drop) else $error("data pins held");
    c_full: cover property (core_wr_valid && !port_ready);
    c_read: cover property (core_rd_req);
    c_tmr: cover property (!port_enabled && timer_on_irq && !timer_b_out);
endmodule
bind hpc_host_port hpc_host_port_chk chk_i (.*);
`default_nettype wire

// [sim/hpc_host_model.sv]
// Purpose: host side of the byte-wide port
// Assumes: shares clk_sys with the port
// Notes: released data pins carry the inverse byte
`default_nettype none
module hpc_host_model (
    input wire logic clk_sys, // clock
    input wire logic port_ready, // ready pin
    input wire logic host_data_oe, // data pins driven
    input wire logic [7:0] host_data_out, // read data
    output logic port_select_n, // select
    output logic data_strobe_a_n, // write strobe
    output logic data_strobe_b_n, // read strobe
    output logic addr_strobe_n, // address strobe
    output logic addr_mux_mode, // latched index
    output logic xfer_direction, // 1 read
    output logic reg_select_0, // index bit 0
    output logic reg_select_1, // index bit 1
    output logic byte_id, // second byte
    output logic [7:0] host_data_in, // data to port
    output logic [7:0] rd_byte, // last read
    output logic timed_out // a wait ran out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {port_select_n, data_strobe_a_n, data_strobe_b_n} = 3'h7;
        {addr_strobe_n, addr_mux_mode, xfer_direction} = 3'h4;
        {reg_select_0, reg_select_1, byte_id, timed_out} = 4'h0;
        {host_data_in, rd_byte} = 16'h0;
    end
    task automatic xfer(input logic rd, mux, bid, input logic [1:0] idx,
            input logic [7:0] d);
        int k;
        for (k = 0; port_ready !== 1'h1 && k < 50; k++) begin
            @(posedge clk_sys);
        end
        if (k >= 50) timed_out <= 1'h1;
        port_select_n <= 1'h0;
        {addr_mux_mode, xfer_direction, byte_id} <= {mux, rd, bid};
        {reg_select_1, reg_select_0, host_data_in} <= {idx, d};
        addr_strobe_n <= !mux;
        repeat (3) @(posedge clk_sys);
        addr_strobe_n <= 1'h1;
        if (mux) {reg_select_1, reg_select_0} <= ~idx;
        @(posedge clk_sys);
        if (rd) data_strobe_b_n <= 1'h0;
        else data_strobe_a_n <= 1'h0;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (rd ? host_data_oe !== 1'h1 && k < 50 : k < 4);
        if (k >= 50) timed_out <= 1'h1;
        rd_byte <= host_data_out;
        {port_select_n, data_strobe_a_n, data_strobe_b_n} <= 3'h7;
        host_data_in <= ~d;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [sim/test_host_port_pin_control.sv]
// Purpose: self-checking bench for host port pin control
// Assumes: 200 MHz clk_sys, host pins from hpc_host_model
// Notes: core side of the port is answered here
`default_nettype none
module test_host_port_pin_control
    import hpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, port_enable_strap, out_disable_n, timer_b_out;
    logic timer_on_irq, core_irq_req, core_rd_valid, core_wr_ready;
    logic [7:0] core_rd_data, host_data_in, host_data_out, rd_byte;
    logic [10:0] core_wr_word;
    logic [1:0] core_rd_index, last_idx;
    logic port_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n;
    logic addr_mux_mode, xfer_direction, reg_select_0, reg_select_1;
    logic byte_id, host_data_oe, core_rd_req, core_wr_valid, port_ready;
    logic port_ready_oe, host_irq_n, host_irq_oe, port_enabled, pullup_on;
    logic timed_out;
    int failures, check_count;
    hpc_host_port #(.FIFO_DEPTH(HPC_FIFO_DEPTH)) dut (.*);
    hpc_host_model host (.*);
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        core_rd_valid <= core_rd_req;
        if (core_rd_req) last_idx <= core_rd_index;
    end
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (!ok) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic do_reset(input logic s);
        port_enable_strap <= s;
        rstn <= 1'h0;
        repeat (2) @(posedge clk_sys);
        chk(host_irq_n === HPC_IRQ_IDLE && pullup_on === 1'h1, "in reset");
        rstn <= 1'h1;
        repeat (4) @(posedge clk_sys);
        chk(port_enabled === s && pullup_on === !s, "strap");
    endtask
    task automatic t_disabled;
        port_enable_strap <= 1'h1;
        timer_on_irq <= 1'h1;
        repeat (3) @(posedge clk_sys);
        chk(port_enabled === 1'h0 && host_irq_n === 1'h0, "timer low");
        timer_b_out <= 1'h1;
        @(posedge clk_sys);
        chk(host_irq_n === 1'h1 && port_ready === 1'h0, "timer high");
        {timer_b_out, timer_on_irq} <= 2'h0;
    endtask
    task automatic t_fill;
        int n;
        core_wr_ready <= 1'h0;
        for (n = 0; n < HPC_FIFO_DEPTH; n++)
            host.xfer(1'h0, 1'h0, n[0], 2'(n % 3), 8'(8'hA0 + n));
        chk(port_ready === 1'h0, "full fifo ready");
        core_wr_ready <= 1'h1;
        n = 0;
        for (int k = 0; n < HPC_FIFO_DEPTH && k < 40; k++) begin
            @(posedge clk_sys);
            if (core_wr_valid === 1'h1) begin
                chk(core_wr_word === {n[0], 2'(n % 3), 8'(8'hA0 + n)}, "word");
                n++;
            end
        end
        @(posedge clk_sys);
        chk(n == HPC_FIFO_DEPTH && port_ready === 1'h1, "drain");
    endtask
    task automatic t_read(input logic m, input logic [1:0] i, logic [7:0] d);
        core_rd_data <= d;
        host.xfer(1'h1, m, 1'h0, i, 8'h00);
        chk(rd_byte === d && last_idx === i, "read");
    endtask
    initial begin
        {rstn, timer_b_out, timer_on_irq, core_irq_req, core_wr_ready} = 5'h0;
        {port_enable_strap, core_rd_data} = 9'h0;
        out_disable_n = 1'h1;
        do_reset(1'h0);
        t_disabled();
        do_reset(1'h1);
        t_fill();
        t_read(1'h1, 2'h2, 8'h5C);
        t_read(1'h0, 2'h1, 8'hA3);
        {out_disable_n, core_irq_req} <= 2'h1;
        repeat (2) @(posedge clk_sys);
        chk(port_ready_oe === 1'h0 && host_irq_oe === 1'h0, "float");
        out_disable_n <= 1'h1;
        @(posedge clk_sys);
        chk(host_irq_n === 1'h0 && timed_out === 1'h0, "irq");
        final_report();
    end
endmodule
`default_nettype wire
